/* csc_pkg.sv */
// Package with register map, field layout and timing constants for the converter control
package csc_pkg;
   localparam logic [11:0] CSC_CTRL_OFS       = 12'h000;
   localparam logic [11:0] CSC_RESULT_OFS     = 12'h004;
   localparam logic [11:0] CSC_PORTC_DATA_OFS = 12'h008;
   localparam logic [11:0] CSC_PORTC_DIR_OFS  = 12'h00C;
   localparam int          CSC_ADDR_W         = 12;
   localparam int CSC_BIT_DONE  = 7;
   localparam int CSC_BIT_RC    = 6;
   localparam int CSC_BIT_PWR   = 5;
   localparam int CSC_CH_LSB    = 0;
   localparam int CSC_CH_W      = 3;
   localparam logic [7:0] CSC_CTRL_RESET  = 8'h00;
   localparam logic [7:0] CSC_PORTC_RESET = 8'h00;
   localparam logic [2:0] CSC_CH_AD0   = 3'h0;
   localparam logic [2:0] CSC_CH_HIGH_REFERENCE = 3'h4;
   localparam logic [2:0] CSC_CH_HALF  = 3'h5;
   localparam logic [2:0] CSC_CH_VSS   = 3'h6;
   localparam logic [2:0] CSC_CH_TEST  = 3'h7;
   localparam int CSC_PIN_AD0   = 6;
   localparam int CSC_PIN_HIGH_REFERENCE = 7;
   localparam int CSC_CONV_CYCLES = 32;
   localparam int CSC_RES_W       = 8;
   localparam logic [7:0] CSC_HALF_CODE = 8'h80;
   localparam logic [7:0] CSC_FULL_CODE = 8'hFF;
   localparam logic [7:0] CSC_ZERO_CODE = 8'h00;
   localparam logic [1:0] CSC_RESP_OKAY   = 2'h0;
   localparam logic [1:0] CSC_RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {CSC_IDLE, CSC_SAMPLE, CSC_SAR} csc_state_t;
endpackage

/* csc_converter_ctrl.sv */
// Conversion sequencer, channel mux, port C override and AXI4-Lite register slave
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module csc_converter_ctrl
   import csc_pkg::*;
#(
   parameter int CONV_CYCLES = CSC_CONV_CYCLES
)(
   input  wire logic        aclk,           // Bus clock, 20 MHz
   input  wire logic        aresetn,        // Synchronous reset, active low
   input  wire logic        rc_clk_tick,    // One pulse per RC oscillator cycle
   input  wire logic        stop_mode,      // Stop instruction executed
   input  wire logic [7:0]  analog_cmp_hi,  // Comparator: input above trial, per channel
   input  wire logic [7:0]  port_c_pins,    // Port C pin levels
   output logic [7:0]       port_c_dir,     // Effective port C direction, 1 = output
   output logic [7:0]       sar_trial,      // Trial code to the D/A
   output logic [2:0]       mux_select,     // Channel steering the analog mux
   output logic             converter_on,   // Analog power enable
   input  wire logic [11:0] s_axi_awaddr,   // Write address
   input  wire logic        s_axi_awvalid,  // Write address valid
   output logic             s_axi_awready,  // Write address ready
   input  wire logic [31:0] s_axi_wdata,    // Write data
   input  wire logic [3:0]  s_axi_wstrb,    // Write strobes
   input  wire logic        s_axi_wvalid,   // Write data valid
   output logic             s_axi_wready,   // Write data ready
   output logic [1:0]       s_axi_bresp,    // Write response
   output logic             s_axi_bvalid,   // Write response valid
   input  wire logic        s_axi_bready,   // Write response ready
   input  wire logic [11:0] s_axi_araddr,   // Read address
   input  wire logic        s_axi_arvalid,  // Read address valid
   output logic             s_axi_arready,  // Read address ready
   output logic [31:0]      s_axi_rdata,    // Read data
   output logic [1:0]       s_axi_rresp,    // Read response
   output logic             s_axi_rvalid,   // Read data valid
   input  wire logic        s_axi_rready    // Read data ready
);
   localparam int CW = $clog2(CONV_CYCLES + 1);
   localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);
   localparam logic [CW-1:0] SAR_START = CW'(CONV_CYCLES - CSC_RES_W);

   // Bus state
   logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
   logic [11:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [3:0]  wstrb_r, wstrb_nxt;
   logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic        arready_r, arready_nxt;
   logic        awready_r, awready_nxt, wready_r, wready_nxt;
   // Converter state
   logic [7:0]  ctrl_r, ctrl_nxt;
   logic [7:0]  portc_data_r, portc_data_nxt, portc_ddr_r, portc_ddr_nxt;
   logic [7:0]  result_r, result_nxt, trial_r, trial_nxt, bit_r, bit_nxt;
   logic        done_r, done_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   csc_state_t  st_r, st_nxt;
   logic [7:0]  dir_r, dir_nxt;
   logic [2:0]  mux_r, mux_nxt;
   logic        on_r, on_nxt;

   logic        wr_fire, rd_fire, ctrl_wr, result_rd, tick, pwr, rc_sel;
   logic [2:0]  chan;
   logic [7:0]  pin_mask, cmp_bit_sel, sar_keep;
   logic        cmp_hi;

   assign pwr    = ctrl_r[CSC_BIT_PWR];
   assign rc_sel = ctrl_r[CSC_BIT_RC];
   assign chan   = ctrl_r[CSC_CH_LSB +: CSC_CH_W];
   // Stop freezes trial and result, and the sequencer clears the count, so an aborted conversion leaves the result unchanged
   assign tick   = !stop_mode && (rc_sel ? rc_clk_tick : 1'b1);
   assign wr_fire = aw_got_r && w_got_r && !bvalid_r;
   assign rd_fire = s_axi_arvalid && arready_r;
   assign ctrl_wr   = wr_fire && (awaddr_r == CSC_CTRL_OFS) && wstrb_r[0];
   assign result_rd = rd_fire && (s_axi_araddr == CSC_RESULT_OFS);
   assign cmp_bit_sel = analog_cmp_hi >> chan;
   assign cmp_hi = cmp_bit_sel[0];
   assign sar_keep = cmp_hi ? trial_r : (trial_r & ~bit_r);

   // Pin owned by the selected channel: codes 0-3 map to pins 6-3, code 4 to pin 7
   always_comb
   begin
      pin_mask = 8'h00;
      if (pwr && chan < CSC_CH_HIGH_REFERENCE)
         pin_mask[CSC_PIN_AD0 - int'(chan)] = 1'b1;
      else if (pwr && chan == CSC_CH_HIGH_REFERENCE)
         pin_mask[CSC_PIN_HIGH_REFERENCE] = 1'b1;
   end

   // Register bus
   always_comb
   begin
      aw_got_nxt = aw_got_r;
      w_got_nxt  = w_got_r;
      awaddr_nxt = awaddr_r;
      wdata_nxt  = wdata_r;
      wstrb_nxt  = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt  = bresp_r;
      rvalid_nxt = rvalid_r;
      rresp_nxt  = rresp_r;
      rdata_nxt  = rdata_r;
      arready_nxt = !rvalid_r && !rd_fire;
      if (s_axi_awvalid && !aw_got_r)
      begin
         aw_got_nxt = 1'b1;
         awaddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_got_r)
      begin
         w_got_nxt = 1'b1;
         wdata_nxt = s_axi_wdata;
         wstrb_nxt = s_axi_wstrb;
      end
      if (wr_fire)
      begin
         aw_got_nxt = 1'b0;
         w_got_nxt  = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt  = (awaddr_r == CSC_CTRL_OFS || awaddr_r == CSC_PORTC_DATA_OFS ||
                       awaddr_r == CSC_PORTC_DIR_OFS) ? CSC_RESP_OKAY : CSC_RESP_SLVERR;
      end
      if (bvalid_r && s_axi_bready)
         bvalid_nxt = 1'b0;
      if (rd_fire)
      begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = CSC_RESP_OKAY;
         case (s_axi_araddr)
            CSC_CTRL_OFS:       rdata_nxt = {24'h000000, done_r, ctrl_r[6:0]};
            CSC_RESULT_OFS:     rdata_nxt = {24'h000000, result_r};
            CSC_PORTC_DATA_OFS: rdata_nxt = {24'h000000, port_c_pins & ~pin_mask};
            CSC_PORTC_DIR_OFS:  rdata_nxt = {24'h000000, dir_r};
            default:
            begin
               rdata_nxt = 32'h00000000;
               rresp_nxt = CSC_RESP_SLVERR;
            end
         endcase
      end
      else if (rvalid_r && s_axi_rready)
         rvalid_nxt = 1'b0;
      // Ready follows the holding flags one edge ahead so the ports come from flops
      awready_nxt = !aw_got_nxt;
      wready_nxt  = !w_got_nxt;
   end

   // Conversion sequencer
   always_comb
   begin
      ctrl_nxt       = ctrl_r;
      portc_data_nxt = portc_data_r;
      portc_ddr_nxt  = portc_ddr_r;
      result_nxt     = result_r;
      trial_nxt      = trial_r;
      bit_nxt        = bit_r;
      done_nxt       = done_r;
      cnt_nxt        = cnt_r;
      st_nxt         = st_r;
      if (wr_fire && wstrb_r[0] && awaddr_r == CSC_PORTC_DATA_OFS)
         portc_data_nxt = wdata_r[7:0];
      if (wr_fire && wstrb_r[0] && awaddr_r == CSC_PORTC_DIR_OFS)
         portc_ddr_nxt = wdata_r[7:0];
      // Cleared before the case so a conversion ending now sets the flag again
      if (result_rd)
         done_nxt = 1'b0;
      // Wait and halt have no input here, so the sequencer keeps running
      case (st_r)
         CSC_IDLE:
         begin
            cnt_nxt = '0;
            if (pwr)
               st_nxt = CSC_SAMPLE;
         end
         CSC_SAMPLE:
            if (tick)
            begin
               cnt_nxt = cnt_r + CW'(1);
               if (cnt_r == SAR_START - CW'(1))
               begin
                  st_nxt    = CSC_SAR;
                  bit_nxt   = CSC_HALF_CODE;
                  trial_nxt = CSC_HALF_CODE;
               end
            end
         CSC_SAR:
            if (tick)
            begin
               if (cnt_r == CONV_LAST)
               begin
                  result_nxt = (chan == CSC_CH_TEST) ? CSC_ZERO_CODE : sar_keep;
                  done_nxt   = 1'b1;
                  cnt_nxt    = '0;
                  st_nxt     = CSC_SAMPLE;
               end
               else
               begin
                  cnt_nxt   = cnt_r + CW'(1);
                  bit_nxt   = bit_r >> 1;
                  trial_nxt = sar_keep | (bit_r >> 1);
               end
            end
         default: st_nxt = CSC_IDLE;
      endcase
      // A control write beats a conversion ending in the same cycle
      if (ctrl_wr)
      begin
         ctrl_nxt = {1'b0, wdata_r[6:0]};
         done_nxt = 1'b0;
         st_nxt   = CSC_IDLE;
      end
      // Power off parks the sequencer
      if (!pwr && !ctrl_wr)
         st_nxt = CSC_IDLE;
      if (stop_mode)
      begin
         st_nxt  = CSC_IDLE;
         cnt_nxt = '0;
      end
      // Stop exit settling is covered by the core's oscillator start-up delay
   end

   always_comb
   begin
      dir_nxt = portc_ddr_r & ~pin_mask;
      mux_nxt = chan;
      on_nxt  = pwr && !stop_mode;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_got_r <= 1'b0;
         w_got_r  <= 1'b0;
         awaddr_r <= '0;
         wdata_r  <= '0;
         wstrb_r  <= '0;
         bvalid_r <= 1'b0;
         bresp_r  <= CSC_RESP_OKAY;
         rvalid_r <= 1'b0;
         rresp_r  <= CSC_RESP_OKAY;
         rdata_r  <= '0;
         arready_r <= 1'b0;
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
         ctrl_r   <= CSC_CTRL_RESET;
         portc_data_r <= CSC_PORTC_RESET;
         portc_ddr_r  <= CSC_PORTC_RESET;
         result_r <= CSC_ZERO_CODE;
         trial_r  <= CSC_ZERO_CODE;
         bit_r    <= CSC_ZERO_CODE;
         done_r   <= 1'b0;
         cnt_r    <= '0;
         st_r     <= CSC_IDLE;
         dir_r    <= CSC_PORTC_RESET;
         mux_r    <= CSC_CH_AD0;
         on_r     <= 1'b0;
      end
      else
      begin
         aw_got_r <= aw_got_nxt;
         w_got_r  <= w_got_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r  <= wdata_nxt;
         wstrb_r  <= wstrb_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r  <= bresp_nxt;
         rvalid_r <= rvalid_nxt;
         rresp_r  <= rresp_nxt;
         rdata_r  <= rdata_nxt;
         arready_r <= arready_nxt;
         awready_r <= awready_nxt;
         wready_r  <= wready_nxt;
         ctrl_r   <= ctrl_nxt;
         portc_data_r <= portc_data_nxt;
         portc_ddr_r  <= portc_ddr_nxt;
         result_r <= result_nxt;
         trial_r  <= trial_nxt;
         bit_r    <= bit_nxt;
         done_r   <= done_nxt;
         cnt_r    <= cnt_nxt;
         st_r     <= st_nxt;
         dir_r    <= dir_nxt;
         mux_r    <= mux_nxt;
         on_r     <= on_nxt;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rresp   = rresp_r;
   assign s_axi_rdata   = rdata_r;
   assign port_c_dir    = dir_r;
   assign sar_trial     = trial_r;
   assign mux_select    = mux_r;
   assign converter_on  = on_r;
endmodule

/* csc_converter_ctrl_properties.sv */
// Port-level assertions for the converter control block
`timescale 1ns/1ps
module csc_converter_ctrl_properties
   import csc_pkg::*;
(
   input wire logic        aclk,          // clock
   input wire logic        aresetn,       // reset
   input wire logic        rc_clk_tick,   // RC tick
   input wire logic        stop_mode,     // stop
   input wire logic [7:0]  port_c_dir,    // pin dir
   input wire logic [7:0]  sar_trial,     // trial
   input wire logic [2:0]  mux_select,    // channel
   input wire logic        converter_on,  // power
   input wire logic [11:0] s_axi_awaddr,  // AW addr
   input wire logic        s_axi_awvalid, // AW valid
   input wire logic        s_axi_awready, // AW ready
   input wire logic [31:0] s_axi_wdata,   // W data
   input wire logic        s_axi_wvalid,  // W valid
   input wire logic        s_axi_wready,  // W ready
   input wire logic [1:0]  s_axi_bresp,   // B resp
   input wire logic        s_axi_bvalid,  // B valid
   input wire logic        s_axi_bready,  // B ready
   input wire logic        s_axi_arready, // AR ready
   input wire logic [31:0] s_axi_rdata,   // R data
   input wire logic        s_axi_rvalid   // R valid
);
   logic [11:0] aw_r, aw_nxt;
   logic [7:0]  wd_r, wd_nxt;
   logic        rc_r, rc_nxt;

   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // Last write seen, and the RC select as software left it
   always_comb
   begin
      aw_nxt = aw_r;
      wd_nxt = wd_r;
      rc_nxt = rc_r;
      if (s_axi_awvalid && s_axi_awready) aw_nxt = s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_nxt = s_axi_wdata[7:0];
      if (s_axi_bvalid && s_axi_bready && aw_r == CSC_CTRL_OFS) rc_nxt = wd_r[CSC_BIT_RC];
      if (!aresetn) rc_nxt = 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      aw_r <= aw_nxt;
      wd_r <= wd_nxt;
      rc_r <= rc_nxt;
   end

   property p_mux_follow;
      $rose(s_axi_bvalid) && aw_r == CSC_CTRL_OFS |-> ##[0:2] mux_select == wd_r[2:0];
   endproperty
   a_mux_follow: assert property (p_mux_follow) else $error("channel not steered");
   property p_dir_force;
      converter_on && $past(converter_on) && $stable(mux_select) && mux_select <= 3'h4
         |-> !port_c_dir[(mux_select == 3'h4) ? 3'd7 : 3'd6 - mux_select];
   endproperty
   a_dir_force: assert property (p_dir_force) else $error("shared pin not input");
   property p_stop_off;
      stop_mode |=> !converter_on;
   endproperty
   a_stop_off: assert property (p_stop_off) else $error("power kept in stop");
   property p_stop_idle;
      stop_mode [*3] |-> $stable(sar_trial);
   endproperty
   a_stop_idle: assert property (p_stop_idle) else $error("sequencer runs in stop");
   // Under the RC clock the trial code may move only on a tick
   property p_rc_hold;
      rc_r && !$past(rc_clk_tick) && !s_axi_bvalid && !$past(s_axi_bvalid) && !stop_mode
         && !$past(stop_mode) |-> $stable(sar_trial);
   endproperty
   a_rc_hold: assert property (p_rc_hold) else $error("trial moved without tick");
   property p_ar_block;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_ar_block: assert property (p_ar_block) else $error("read taken while pending");
   property p_rd_upper;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
   endproperty
   a_rd_upper: assert property (p_rd_upper) else $error("upper read bits set");
   property p_bresp_err;
      $rose(s_axi_bvalid) && aw_r > CSC_PORTC_DIR_OFS |-> s_axi_bresp == CSC_RESP_SLVERR;
   endproperty
   a_bresp_err: assert property (p_bresp_err) else $error("unmapped write accepted");
endmodule

bind csc_converter_ctrl csc_converter_ctrl_properties csc_converter_ctrl_properties_inst (
   .aclk, .aresetn, .rc_clk_tick, .stop_mode, .port_c_dir, .sar_trial, .mux_select,
   .converter_on, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arready, .s_axi_rdata, .s_axi_rvalid
);

/* csc_converter_ctrl_tb.sv */
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module csc_converter_ctrl_tb
   import csc_pkg::*;
;
   logic        aclk = 1'b0, aresetn = 1'b0, rc_clk_tick = 1'b0, stop_mode = 1'b0;
   logic [7:0]  analog_cmp_hi, port_c_dir, sar_trial, d, exp_v, mask;
   logic [7:0]  port_c_pins = 8'hFF;
   logic [2:0]  mux_select;
   logic        converter_on, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, tick_en = 1'b0;
   logic [1:0]  tick_div = 2'h0;
   logic [7:0]  ain [8];
   int          errors = 0, num_checks = 0, cyc = 0, el;

   csc_converter_ctrl csc_converter_ctrl_inst (.aclk, .aresetn, .rc_clk_tick, .stop_mode,
      .analog_cmp_hi, .port_c_pins, .port_c_dir, .sar_trial, .mux_select, .converter_on,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);

   always #25 aclk = ~aclk;

   // Comparator of each channel against the trial code
   always_comb
   begin
      for (int i = 0; i < 8; i++)
         analog_cmp_hi[i] = ain[i] >= sar_trial;
   end

   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      tick_div <= tick_div + 2'h1;
      rc_clk_tick <= tick_en && tick_div == 2'h0;
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      check("bresp", s_axi_bresp, er);
   endtask

   task automatic rd(input logic [11:0] a, output logic [7:0] v, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      v = s_axi_rdata[7:0];
      check("rresp", s_axi_rresp, er);
   endtask

   task automatic rd_chk(input string name, input logic [11:0] a, input logic [7:0] e);
      logic [7:0] v;
      rd(a, v, CSC_RESP_OKAY);
      check(name, v, e);
   endtask

   // Polls the status register until a conversion has finished
   task automatic wait_done(output int t);
      int t0;
      t0 = cyc;
      do rd(CSC_CTRL_OFS, d, CSC_RESP_OKAY);
      while (d[CSC_BIT_DONE] !== 1'b1);
      t = cyc - t0;
   endtask

   task automatic tally_and_finish;
      if (errors == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      repeat (20000) @(posedge aclk);
      errors++;
      tally_and_finish;
   end

   initial
   begin
      ain = '{8'h3C, 8'hA5, 8'h5A, 8'hC3, 8'hFF, 8'h80, 8'h00, 8'hFF};
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rd_chk("ctrl reset", CSC_CTRL_OFS, CSC_CTRL_RESET);
      rd_chk("dir reset", CSC_PORTC_DIR_OFS, CSC_PORTC_RESET);
      rd(12'h010, d, CSC_RESP_SLVERR);
      check("unmapped", d, 8'h00);
      wr(12'h010, 8'h55, CSC_RESP_SLVERR);
      wr(CSC_PORTC_DIR_OFS, 8'hFF, CSC_RESP_OKAY);
      for (int ch = 0; ch < 8; ch++)
      begin
         wr(CSC_CTRL_OFS, 8'h20 | 8'(ch), CSC_RESP_OKAY);
         wait_done(el);
         check("conv time", el > CSC_CONV_CYCLES && el <= CSC_CONV_CYCLES + 6, 1'b1);
         exp_v = (ch == 7) ? 8'h00 : ain[ch];
         rd_chk("result", CSC_RESULT_OFS, exp_v);
         rd_chk("done cleared", CSC_CTRL_OFS, 8'h20 | 8'(ch));
         mask = (ch > 4) ? 8'h00 : (ch == 4) ? 8'h80 : 8'h40 >> ch;
         exp_v = ~mask;
         check("dir", port_c_dir, exp_v);
         rd_chk("pins", CSC_PORTC_DATA_OFS, exp_v);
      end
      wr(CSC_CTRL_OFS, 8'h20, CSC_RESP_OKAY);
      wait_done(el);
      ain[0] <= 8'h6B;
      repeat (80) @(posedge aclk);
      rd_chk("overwrite", CSC_RESULT_OFS, 8'h6B);
      wr(CSC_CTRL_OFS, 8'h00, CSC_RESP_OKAY);
      port_c_pins <= 8'h5A;
      repeat (3) @(posedge aclk);
      check("dir off", port_c_dir, 8'hFF);
      rd_chk("pins off", CSC_PORTC_DATA_OFS, 8'h5A);
      wr(CSC_CTRL_OFS, 8'h61, CSC_RESP_OKAY);
      repeat (100) @(posedge aclk);
      rd_chk("no tick", CSC_CTRL_OFS, 8'h61);
      tick_en <= 1'b1;
      wait_done(el);
      check("rc time", el > 3 * CSC_CONV_CYCLES, 1'b1);
      rd_chk("rc result", CSC_RESULT_OFS, 8'hA5);
      tick_en <= 1'b0;
      wr(CSC_CTRL_OFS, 8'h22, CSC_RESP_OKAY);
      repeat (10) @(posedge aclk);
      stop_mode <= 1'b1;
      repeat (60) @(posedge aclk);
      rd_chk("stop abort", CSC_CTRL_OFS, 8'h22);
      rd_chk("stop result", CSC_RESULT_OFS, 8'hA5);
      stop_mode <= 1'b0;
      tally_and_finish;
   end
endmodule
